// ===== hdl/dpc_pkg.sv
// Package for the dual-port RAM host-side port controller.
// Assumes a 25 MHz ref_clk; times are converted to whole clock cycles.
package dpc_pkg;
    // Clock period in ps
    localparam int CLK_PERIOD_PS = 40000;
    // Array geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    // Master arbitration time (busy access from address), ns, maximum
    localparam int ARB_TIME_NS = 45;
    // Write hold after busy released, ns, minimum
    localparam int WR_HOLD_NS = 30;
    // Write pulse width, ns, minimum
    localparam int WR_PULSE_NS = 50;
    // Busy disable to valid data, ns, maximum wait before sampling
    localparam int BUSY_DATA_NS = 40;
    // Read access time, ns
    localparam int RD_ACCESS_NS = 90;
    // Least times round up, none under one cycle
    localparam int ARB_CYC =
        (ARB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC =
        (WR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_CYC =
        (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BDD_CYC =
        (BUSY_DATA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RD_CYC =
        (RD_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;
    // Port sequencer states
    typedef enum logic [2:0] {
        DPC_IDLE,
        DPC_SETUP,
        DPC_ARB,
        DPC_PULSE,
        DPC_HOLD,
        DPC_READ,
        DPC_DONE
    } dpc_state_e;
endpackage

// ===== hdl/dpc_busy_sync.sv
// Busy flag conditioner: two-flop sampling of both active-low busy lines.
// Assumes the busy lines arrive already resolved from open-drain wires.
`timescale 1ns/100ps
module dpc_busy_sync
(
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic left_flag_n,
    input  wire logic right_flag_n,
    output logic      left_busy,
    output logic      right_busy
);
    logic [1:0] l_r, l_nxt;
    logic [1:0] r_r, r_nxt;

    // Shift sampled levels; only the second stage is looked at
    always_comb
    begin
        l_nxt = {l_r[0], ~left_flag_n};
        r_nxt = {r_r[0], ~right_flag_n};
    end

    // Register stage, idle means not busy
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            l_r <= 2'h0;
            r_r <= 2'h0;
        end
        else
        begin
            l_r <= l_nxt;
            r_r <= r_nxt;
        end
    end

    assign left_busy  = l_r[1];
    assign right_busy = r_r[1];
endmodule

// ===== hdl/dpc_port_ctrl.sv
// Host-side controller for one port pair of a master/slave dual-port
// SRAM array. Drives the left and right port pins, defers slave writes
// past arbitration and stretches the strobe past busy release.
// Assumes the RAM is asynchronous and the busy wires have pull-ups.
//
// Overview of operation
// - Both slave busy inputs high: normal
// - Busy held low blocks every write
// - One master arbitrates; slaves only inhibit
// - Delay slave write past master arbitration
// - Hold write pulse after busy release
// - ORed busy flags may flag collision
// - Select or strobe high on address change
`timescale 1ns/100ps
module dpc_port_ctrl
#(
    parameter int ADDR_W = dpc_pkg::ADDR_W,
    parameter int DATA_W = dpc_pkg::DATA_W
)
(
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // User request, one per side; index 0 left, 1 right
    input  wire logic [1:0]        req_valid,
    input  wire logic [1:0]        req_write,
    input  wire logic [3:0]        req_byte_en,
    input  wire logic [2*ADDR_W-1:0] req_addr,
    input  wire logic [2*DATA_W-1:0] req_wdata,
    output logic [1:0]             req_ready,
    output logic [1:0]             rsp_valid,
    output logic [2*DATA_W-1:0]    rsp_rdata,
    output logic                   contention_irq,
    // RAM pins
    output logic                   left_port_select_n,
    output logic                   right_port_select_n,
    output logic [1:0]             out_enable_n,
    output logic [1:0]             low_byte_write_n,
    output logic [1:0]             high_byte_write_n,
    output logic [2*ADDR_W-1:0]    ram_addr,
    output logic [2*DATA_W-1:0]    ram_dq_o,
    output logic [1:0]             ram_dq_oe,
    input  wire logic [2*DATA_W-1:0] ram_dq_i,
    input  wire logic              left_contention_flag_n,
    input  wire logic              right_contention_flag_n
);
    logic [1:0] busy;
    logic [1:0] sel_n_r;

    // Busy lines come from the master only; slaves share them
    // Released lines read high, so writes run normally
    dpc_busy_sync u_busy
    (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .left_flag_n  (left_contention_flag_n),
        .right_flag_n (right_contention_flag_n),
        .left_busy    (busy[0]),
        .right_busy   (busy[1])
    );

    assign left_port_select_n  = sel_n_r[0];
    assign right_port_select_n = sel_n_r[1];

    // Collision flag: OR of both busy lines, registered
    logic irq_r, irq_nxt;
    always_comb
    begin
        irq_nxt = busy[0] | busy[1];
    end
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            irq_r <= 1'b0;
        else
            irq_r <= irq_nxt;
    end
    assign contention_irq = irq_r;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_side
            dpc_pkg::dpc_state_e st_r, st_nxt;
            logic [dpc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
            logic [ADDR_W-1:0] a_r, a_nxt;
            logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
            logic [1:0] be_r, be_nxt;
            logic wr_r, wr_nxt;
            logic seln_r, seln_nxt, oen_r, oen_nxt;
            logic lbn_r, lbn_nxt, hbn_r, hbn_nxt, oe_r, oe_nxt;
            logic rdy_r, rdy_nxt, vld_r, vld_nxt;

            // Sequencer: address set with strobes high, then select,
            // then deferred strobe, held until busy clears plus hold
            always_comb
            begin
                st_nxt   = st_r;
                cnt_nxt  = cnt_r;
                a_nxt    = a_r;
                wd_nxt   = wd_r;
                rd_nxt   = rd_r;
                be_nxt   = be_r;
                wr_nxt   = wr_r;
                seln_nxt = seln_r;
                oen_nxt  = oen_r;
                lbn_nxt  = lbn_r;
                hbn_nxt  = hbn_r;
                oe_nxt   = oe_r;
                rdy_nxt  = rdy_r;
                vld_nxt  = 1'b0;
                case (st_r)
                    dpc_pkg::DPC_IDLE:
                    begin
                        if (req_valid[g] && rdy_r)
                        begin
                            // Address only moves while deselected
                            a_nxt   = req_addr[g*ADDR_W +: ADDR_W];
                            wd_nxt  = req_wdata[g*DATA_W +: DATA_W];
                            be_nxt  = req_byte_en[2*g +: 2];
                            wr_nxt  = req_write[g];
                            rdy_nxt = 1'b0;
                            st_nxt  = dpc_pkg::DPC_SETUP;
                        end
                    end
                    dpc_pkg::DPC_SETUP:
                    begin
                        seln_nxt = 1'b0;
                        cnt_nxt  = dpc_pkg::CNT_W'(dpc_pkg::ARB_CYC);
                        st_nxt   = dpc_pkg::DPC_ARB;
                        if (!wr_r)
                            oen_nxt = 1'b0;
                        else
                            oe_nxt = 1'b1;
                    end
                    dpc_pkg::DPC_ARB:
                    begin
                        // Wait out master arbitration before strobing
                        if (cnt_r != '0)
                            cnt_nxt = cnt_r - 1'b1;
                        else if (wr_r)
                        begin
                            lbn_nxt = ~be_r[0];
                            hbn_nxt = ~be_r[1];
                            cnt_nxt = dpc_pkg::CNT_W'(dpc_pkg::PULSE_CYC);
                            st_nxt  = dpc_pkg::DPC_PULSE;
                        end
                        else
                        begin
                            cnt_nxt = dpc_pkg::CNT_W'(dpc_pkg::RD_CYC);
                            st_nxt  = dpc_pkg::DPC_READ;
                        end
                    end
                    dpc_pkg::DPC_PULSE:
                    begin
                        // Busy keeps the strobe low, device blocks it
                        // A flag tied low stalls the port for good
                        if (busy[g])
                            cnt_nxt = dpc_pkg::CNT_W'(dpc_pkg::HOLD_CYC);
                        else if (cnt_r != '0)
                            cnt_nxt = cnt_r - 1'b1;
                        else
                        begin
                            cnt_nxt = dpc_pkg::CNT_W'(dpc_pkg::HOLD_CYC);
                            st_nxt  = dpc_pkg::DPC_HOLD;
                        end
                    end
                    dpc_pkg::DPC_HOLD:
                    begin
                        // Strobe stays past busy release
                        if (busy[g])
                            st_nxt = dpc_pkg::DPC_PULSE;
                        else if (cnt_r != '0)
                            cnt_nxt = cnt_r - 1'b1;
                        else
                        begin
                            // Strobes rise first, ending the write
                            lbn_nxt = 1'b1;
                            hbn_nxt = 1'b1;
                            oe_nxt  = 1'b0;
                            st_nxt  = dpc_pkg::DPC_DONE;
                        end
                    end
                    dpc_pkg::DPC_READ:
                    begin
                        // Data is unsure while busy; restart wait
                        if (busy[g])
                            cnt_nxt = dpc_pkg::CNT_W'(dpc_pkg::BDD_CYC);
                        else if (cnt_r != '0)
                            cnt_nxt = cnt_r - 1'b1;
                        else
                        begin
                            rd_nxt  = ram_dq_i[g*DATA_W +: DATA_W];
                            vld_nxt = 1'b1;
                            st_nxt  = dpc_pkg::DPC_DONE;
                        end
                    end
                    dpc_pkg::DPC_DONE:
                    begin
                        // Deselect: port floats and idles
                        seln_nxt = 1'b1;
                        oen_nxt  = 1'b1;
                        vld_nxt  = wr_r;
                        rdy_nxt  = 1'b1;
                        st_nxt   = dpc_pkg::DPC_IDLE;
                    end
                    default:
                        st_nxt = dpc_pkg::DPC_IDLE;
                endcase
            end

            always_ff @(posedge ref_clk)
            begin
                if (!reset_n)
                begin
                    st_r   <= dpc_pkg::DPC_IDLE;
                    cnt_r  <= '0;
                    a_r    <= '0;
                    wd_r   <= '0;
                    rd_r   <= '0;
                    be_r   <= 2'h0;
                    wr_r   <= 1'b0;
                    seln_r <= 1'b1;
                    oen_r  <= 1'b1;
                    lbn_r  <= 1'b1;
                    hbn_r  <= 1'b1;
                    oe_r   <= 1'b0;
                    rdy_r  <= 1'b1;
                    vld_r  <= 1'b0;
                end
                else
                begin
                    st_r   <= st_nxt;
                    cnt_r  <= cnt_nxt;
                    a_r    <= a_nxt;
                    wd_r   <= wd_nxt;
                    rd_r   <= rd_nxt;
                    be_r   <= be_nxt;
                    wr_r   <= wr_nxt;
                    seln_r <= seln_nxt;
                    oen_r  <= oen_nxt;
                    lbn_r  <= lbn_nxt;
                    hbn_r  <= hbn_nxt;
                    oe_r   <= oe_nxt;
                    rdy_r  <= rdy_nxt;
                    vld_r  <= vld_nxt;
                end
            end

            assign sel_n_r[g]                   = seln_r;
            assign out_enable_n[g]              = oen_r;
            assign low_byte_write_n[g]          = lbn_r;
            assign high_byte_write_n[g]         = hbn_r;
            assign ram_addr[g*ADDR_W +: ADDR_W] = a_r;
            assign ram_dq_o[g*DATA_W +: DATA_W] = wd_r;
            assign ram_dq_oe[g]                 = oe_r;
            assign rsp_rdata[g*DATA_W +: DATA_W] = rd_r;
            assign req_ready[g]                 = rdy_r;
            assign rsp_valid[g]                 = vld_r;
        end
    endgenerate
endmodule

// ===== sim/dpc_port_ctrl_properties.sv
// Pin checker for the dual-port RAM host controller.
// Assumes it is bound into dpc_port_ctrl and sees only its ports.
`timescale 1ns/100ps
module dpc_port_ctrl_properties
(
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic [1:0]  req_ready,
    input wire logic        contention_irq,
    input wire logic        left_port_select_n,
    input wire logic        right_port_select_n,
    input wire logic [1:0]  out_enable_n,
    input wire logic [1:0]  low_byte_write_n,
    input wire logic [1:0]  high_byte_write_n,
    input wire logic [21:0] ram_addr,
    input wire logic [1:0]  ram_dq_oe,
    input wire logic        left_contention_flag_n,
    input wire logic        right_contention_flag_n
);
    // Either strobe of a side low means that side writes
    wire wr_l = !(low_byte_write_n[0] && high_byte_write_n[0]);
    wire wr_r = !(low_byte_write_n[1] && high_byte_write_n[1]);
    wire any_busy = !(left_contention_flag_n && right_contention_flag_n);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Busy held a while, and busy let go while still writing
    sequence s_busy_l;
        !left_contention_flag_n [*3];
    endsequence
    sequence s_release_l;
        $rose(left_contention_flag_n) ##0 wr_l;
    endsequence

    a_reset_values: assert property (disable iff (1'b0) !reset_n |=>
        left_port_select_n && right_port_select_n && &out_enable_n
        && !wr_l && !wr_r && ram_dq_oe == 2'b00 && req_ready == 2'b11)
        else $error("pins not idle after reset");
    a_idle_left: assert property (left_port_select_n |->
        !wr_l && out_enable_n[0] && !ram_dq_oe[0])
        else $error("deselected left port not idle");
    a_idle_right: assert property (right_port_select_n |->
        !wr_r && out_enable_n[1] && !ram_dq_oe[1])
        else $error("deselected right port not idle");
    a_write_drives: assert property (wr_l |-> !left_port_select_n
        && ram_dq_oe[0] && out_enable_n[0])
        else $error("left write without select or data");
    a_arb_delay: assert property ($rose(wr_l) |->
        $past(left_port_select_n, 2) == 1'b0)
        else $error("left strobe before arbitration settled");
    a_addr_quiet: assert property ($changed(ram_addr[10:0]) |->
        !wr_l && !$past(wr_l))
        else $error("left address moved during write");
    a_busy_stalls: assert property (s_busy_l ##0 wr_l |=> wr_l)
        else $error("left strobe ended while busy");
    a_hold_release: assert property (s_release_l |=> wr_l [*2])
        else $error("left strobe short after busy release");
    a_irq_follows: assert property (any_busy [*3] |=> contention_irq)
        else $error("busy not flagged");
    a_irq_clears: assert property (!any_busy [*4] |-> !contention_irq)
        else $error("flag stuck without busy");
endmodule

bind dpc_port_ctrl dpc_port_ctrl_properties i_dpc_port_ctrl_properties (
    .ref_clk(ref_clk), .reset_n(reset_n), .req_ready(req_ready),
    .contention_irq(contention_irq), .out_enable_n(out_enable_n),
    .left_port_select_n(left_port_select_n),
    .right_port_select_n(right_port_select_n),
    .low_byte_write_n(low_byte_write_n),
    .high_byte_write_n(high_byte_write_n),
    .ram_addr(ram_addr), .ram_dq_oe(ram_dq_oe),
    .left_contention_flag_n(left_contention_flag_n),
    .right_contention_flag_n(right_contention_flag_n)
);

// ===== sim/dpc_ram_model.sv
// Behavioural dual-port RAM with the master arbiter.
// Assumes busy wires have pull-ups: released means high.
`timescale 1ns/100ps
module dpc_ram_model
(
    input wire logic [1:0]  sel_n,
    input wire logic [1:0]  oe_n,
    input wire logic [3:0]  wr_n,
    input wire logic [21:0] addr,
    input wire logic [31:0] dq_o,
    input wire logic [1:0]  dq_oe,
    output logic [31:0]     dq_i,
    output logic [1:0]      busy_n
);
    logic [7:0]  mem [2][2048];
    logic [31:0] held;
    realtime     t [2];
    logic [1:0]  busy;
    bit          flip;

    // Floated lines move, so a stale value never passes
    always #13 flip = !flip;

    // Time each side's address and select last moved
    always @(addr[10:0] or sel_n[0]) t[0] = $realtime;
    always @(addr[21:11] or sel_n[1]) t[1] = $realtime;

    // Single arbiter; a tie gives busy to the left
    // Slaves in the array only inhibit on these flags
    always @*
    begin
        busy = 2'b00;
        if (sel_n == 2'b00 && addr[10:0] == addr[21:11])
            busy = (t[0] >= t[1]) ? 2'b01 : 2'b10;
    end
    assign busy_n = ~busy;

    // Bytes written during select and strobe overlap
    always @*
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (dq_oe[i/2])
                held[8*i+:8] = dq_o[8*i+:8];
            if (!sel_n[i/2] && !wr_n[i] && !busy[i/2])
                mem[i%2][addr[11*(i/2)+:11]] = held[8*i+:8];
            if (!sel_n[i/2] && !oe_n[i/2] && wr_n[i] && !busy[i/2])
                dq_i[8*i+:8] = mem[i%2][addr[11*(i/2)+:11]];
            else
                dq_i[8*i+:8] = {8{flip}} ^ 8'h3c;
        end
    end
endmodule

// ===== sim/dual_port_ram_contention_arbiter_test.sv
// Self-checking bench for the dual-port RAM host controller.
// Assumes the RAM model and the bound checker are compiled first.
`timescale 1ns/100ps
module dual_port_ram_contention_arbiter_test;
    logic        ref_clk     = 1'b0;
    logic        reset_n     = 1'b0;
    logic [1:0]  req_valid   = 2'b00;
    logic [1:0]  req_write   = 2'b00;
    logic [3:0]  req_byte_en = 4'h0;
    logic [21:0] req_addr    = 22'h000000;
    logic [31:0] req_wdata   = 32'h00000000;
    logic [1:0]  req_ready, rsp_valid, oe_n, lbw_n, hbw_n, dq_oe, busy_n;
    logic [31:0] rsp_rdata, dq_o, dq_i, rd;
    logic [21:0] ram_addr;
    logic        irq, sel_l_n, sel_r_n, seen_irq;
    int          errors      = 0;
    int          check_count = 0;
    int          cycles      = 0;

    // Controller and RAM model face each other
    dpc_port_ctrl i_dpc_port_ctrl (
        .ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_write(req_write), .req_byte_en(req_byte_en),
        .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .contention_irq(irq),
        .left_port_select_n(sel_l_n), .right_port_select_n(sel_r_n),
        .out_enable_n(oe_n), .low_byte_write_n(lbw_n),
        .high_byte_write_n(hbw_n), .ram_addr(ram_addr),
        .ram_dq_o(dq_o), .ram_dq_oe(dq_oe), .ram_dq_i(dq_i),
        .left_contention_flag_n(busy_n[0]),
        .right_contention_flag_n(busy_n[1])
    );
    dpc_ram_model i_dpc_ram_model (
        .sel_n({sel_r_n, sel_l_n}), .oe_n(oe_n),
        .wr_n({hbw_n[1], lbw_n[1], hbw_n[0], lbw_n[0]}),
        .addr(ram_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
        .busy_n(busy_n)
    );

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    // A hung handshake is cut short far past the longest run
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Launch one request per chosen side together, wait for every answer
    task automatic xfer(input logic [1:0] v, input logic [1:0] w,
        input logic [3:0] be, input logic [21:0] a, input logic [31:0] d);
        logic [1:0] got;
        got = 2'b00;
        @(posedge ref_clk);
        req_valid   <= v;
        req_write   <= w;
        req_byte_en <= be;
        req_addr    <= a;
        req_wdata   <= d;
        @(negedge ref_clk);
        while ((req_ready & v) !== v)
            @(negedge ref_clk);
        @(posedge ref_clk);
        req_valid <= 2'b00;
        for (int n = 0; n < 300 && got !== v; n++)
        begin
            @(negedge ref_clk);
            seen_irq = seen_irq | irq;
            if (rsp_valid[0])
                rd[15:0] = rsp_rdata[15:0];
            if (rsp_valid[1])
                rd[31:16] = rsp_rdata[31:16];
            got = got | rsp_valid;
        end
        check({14'h0000, got}, {14'h0000, v});
    endtask

    // Each port reads what the other wrote, at both ends of the array
    task automatic t_ports();
        xfer(2'b01, 2'b01, 4'h3, {11'h000, 11'h7ff}, 32'h0000beef);
        xfer(2'b10, 2'b00, 4'h0, {11'h7ff, 11'h000}, 32'h00000000);
        check(rd[31:16], 16'hbeef);
        xfer(2'b10, 2'b10, 4'hc, 22'h000000, 32'h43210000);
        xfer(2'b01, 2'b00, 4'h0, 22'h000000, 32'h00000000);
        check(rd[15:0], 16'h4321);
    endtask

    // Both bytes, low only, high only, then no byte enables at all
    task automatic t_bytes();
        xfer(2'b01, 2'b01, 4'h3, 22'h000005, 32'h00001234);
        xfer(2'b01, 2'b01, 4'h1, 22'h000005, 32'h0000aa55);
        xfer(2'b01, 2'b01, 4'h2, 22'h000005, 32'h0000cc77);
        xfer(2'b01, 2'b01, 4'h0, 22'h000005, 32'h0000ffff);
        xfer(2'b10, 2'b00, 4'h0, {11'h005, 11'h000}, 32'h00000000);
        check(rd[31:16], 16'hcc55);
    endtask

    // Same address from both sides; left loses the tie so lands last
    task automatic t_contend();
        seen_irq = 1'b0;
        xfer(2'b11, 2'b11, 4'hf, {11'h0a0, 11'h0a0}, 32'h22221111);
        check({15'h0000, seen_irq}, 16'h0001);
        xfer(2'b11, 2'b00, 4'h0, {11'h0a0, 11'h0a0}, 32'h00000000);
        check(rd[15:0], 16'h1111);
        check(rd[31:16], 16'h1111);
    endtask

    // Reset for three cycles, then the scenarios in turn
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        check({1'b0, sel_l_n, sel_r_n, oe_n, lbw_n, hbw_n, dq_oe,
               req_ready, rsp_valid, irq}, 16'h7f98);
        t_ports();
        t_bytes();
        t_contend();
        print_verdict();
    end
endmodule
